// ---- verilog/fspd_cfg.svh ----
// Register offsets, field limits and tuning constants for the frame statistics block.
// Assumes inclusion by the package and design files by bare name.
`ifndef FSPD_CFG_SVH
`define FSPD_CFG_SVH

`define FSPD_ADDR_W 7
`define FSPD_ADDR_SHUT_UP 7'h06
`define FSPD_ADDR_SHUT_LO 7'h07
`define FSPD_ADDR_PEAK 7'h08
`define FSPD_ADDR_TOTAL 7'h09
`define FSPD_ADDR_FLOOR 7'h0A
`define FSPD_ADDR_DUMP 7'h0B

`define FSPD_PIX_LAST 9'h168
`define FSPD_STAT_CEIL 8'hFE
`define FSPD_SUM_CEIL 8'hF0
`define FSPD_SUM_LSB 9

`define FSPD_SHUT_RST 16'h0100
`define FSPD_SHUT_MIN 16'h0001
`define FSPD_SHUT_MAX 16'hFFF0
`define FSPD_SHUT_STEP 16'h0010
`define FSPD_PEAK_HI 8'hE0
`define FSPD_AVG_HI 8'hA0
`define FSPD_AVG_LO 8'h40

`endif

// ---- verilog/fspd_pkg.sv ----
// Types shared by the frame statistics and pixel dump block.
// Assumes the constants header is on the include path.
`include "fspd_cfg.svh"

package fspd_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`FSPD_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } fspd_req_type;

    typedef struct packed {
        logic sof;
        logic [7:0] data;
    } fspd_beat_type;

endpackage : fspd_pkg

// ---- verilog/fspd_exposure.sv ----
// Automatic exposure control: at most one shutter step per completed frame.
// Assumes frame_done_i is a one-cycle pulse with the latched statistics valid.
`timescale 1ns/1ps
`include "fspd_cfg.svh"

module fspd_exposure #(
    parameter logic [15:0] SHUT_MIN = `FSPD_SHUT_MIN,
    parameter logic [15:0] SHUT_MAX = `FSPD_SHUT_MAX,
    parameter logic [15:0] SHUT_STEP = `FSPD_SHUT_STEP
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Frame statistics
    input wire logic frame_done_i,
    input wire logic [7:0] peak_i,
    input wire logic [7:0] total_i,
    // Exposure value
    output logic [15:0] shutter_o
);
    logic [15:0] shut_reg;
    logic [15:0] shut_next;

    // Too bright shortens exposure; peak guard wins so highlights never clip
    always_comb begin
        shut_next = shut_reg;
        if (frame_done_i) begin
            if (peak_i > `FSPD_PEAK_HI || total_i > `FSPD_AVG_HI) begin
                shut_next = (shut_reg > SHUT_MIN + SHUT_STEP) ? shut_reg - SHUT_STEP : SHUT_MIN;
            end else if (total_i < `FSPD_AVG_LO) begin
                shut_next = (shut_reg < SHUT_MAX - SHUT_STEP) ? shut_reg + SHUT_STEP : SHUT_MAX;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shut_reg <= `FSPD_SHUT_RST;
        end else begin
            shut_reg <= shut_next;
        end
    end

    assign shutter_o = shut_reg;

    shut_frame_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !frame_done_i |=> $stable(shut_reg))
        else $error("shutter moved without a frame");

    shut_bright_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_done_i && peak_i > `FSPD_PEAK_HI && shut_reg > SHUT_MIN |=> shut_reg < $past(shut_reg))
        else $error("shutter not shortened on bright frame");

    shut_bounds_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 shut_reg >= SHUT_MIN && shut_reg <= SHUT_MAX)
        else $error("shutter out of range");

endmodule : fspd_exposure

// ---- verilog/fspd_top.sv ----
// Frame statistics, exposure readout and test pixel dump behind the register port.
// Assumes a decoded register port and an in-order pixel stream, sof on pixel 0.
//
// Contract
// - Exposure is a 16-bit clock-cycle count, split over upper and lower bytes.
// - Exposure adjusts itself to hold average and peak intensity in range.
// - Brightest pixel of the frame reads as one byte, 0 to 254.
// - Frame pixel sum is 17 bits; report its upper eight bits, sum over 512.
// - Reported sum byte ranges 0 to 240, may change every frame.
// - Darkest pixel of the frame reads as one byte, 0 to 254.
// - Any write to the dump port resets the pointer to pixel 0,0.
// - One pixel per frame is captured; ready flag rises when valid.
// - Reading the dump port while the ready flag is set advances the pointer to the next pixel.
// - After the last pixel the pointer wraps to start and sets the wrap flag.
// - Pixel addresses run 0 to 360 over 19 by 19, row by row.
// - A write to the dump port also sets the wrap flag.
`timescale 1ns/1ps
`include "fspd_cfg.svh"

module fspd_top #(
    parameter int PIX_W = 8,
    parameter logic [8:0] PIX_LAST = `FSPD_PIX_LAST
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input fspd_pkg::fspd_req_type req_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // Pixel stream from the array
    input wire logic pix_valid_i,
    input fspd_pkg::fspd_beat_type pix_beat_i,
    // Status bits for the motion status register
    output logic dump_byte_ready_flag_o,
    output logic dump_wrap_flag_o
);
    import fspd_pkg::*;

    // Frame accumulation and latched statistics
    logic [8:0] idx_reg;
    logic [8:0] idx_next;
    logic [7:0] acc_max_reg;
    logic [7:0] acc_max_next;
    logic [7:0] acc_min_reg;
    logic [7:0] acc_min_next;
    logic [16:0] acc_sum_reg;
    logic [16:0] acc_sum_next;
    logic [7:0] peak_reg;
    logic [7:0] peak_next;
    logic [7:0] floor_reg;
    logic [7:0] floor_next;
    logic [7:0] total_reg;
    logic [7:0] total_next;
    logic frame_done_reg;
    logic frame_done_next;
    logic [8:0] cur_idx;
    logic frame_end;
    logic [7:0] sum_hi;

    always_comb begin
        cur_idx = pix_beat_i.sof ? 9'h000 : idx_reg;
        frame_end = pix_valid_i && (cur_idx == PIX_LAST);
        idx_next = idx_reg;
        acc_max_next = acc_max_reg;
        acc_min_next = acc_min_reg;
        acc_sum_next = acc_sum_reg;
        if (pix_valid_i) begin
            idx_next = cur_idx + 9'h001;
            if (pix_beat_i.sof) begin
                acc_max_next = pix_beat_i.data;
                acc_min_next = pix_beat_i.data;
                acc_sum_next = {9'h000, pix_beat_i.data};
            end else begin
                acc_max_next = (pix_beat_i.data > acc_max_reg) ? pix_beat_i.data : acc_max_reg;
                acc_min_next = (pix_beat_i.data < acc_min_reg) ? pix_beat_i.data : acc_min_reg;
                acc_sum_next = acc_sum_reg + {9'h000, pix_beat_i.data};
            end
        end
        sum_hi = acc_sum_next[16:`FSPD_SUM_LSB];
        peak_next = peak_reg;
        floor_next = floor_reg;
        total_next = total_reg;
        frame_done_next = frame_end;
        // Latch only at the last pixel so a read never mixes two frames
        if (frame_end) begin
            peak_next = (acc_max_next > `FSPD_STAT_CEIL) ? `FSPD_STAT_CEIL : acc_max_next;
            floor_next = (acc_min_next > `FSPD_STAT_CEIL) ? `FSPD_STAT_CEIL : acc_min_next;
            total_next = (sum_hi > `FSPD_SUM_CEIL) ? `FSPD_SUM_CEIL : sum_hi;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idx_reg <= 9'h000;
            acc_max_reg <= 8'h00;
            acc_min_reg <= 8'hFF;
            acc_sum_reg <= 17'h00000;
            peak_reg <= 8'h00;
            floor_reg <= 8'h00;
            total_reg <= 8'h00;
            frame_done_reg <= 1'b0;
        end else begin
            idx_reg <= idx_next;
            acc_max_reg <= acc_max_next;
            acc_min_reg <= acc_min_next;
            acc_sum_reg <= acc_sum_next;
            peak_reg <= peak_next;
            floor_reg <= floor_next;
            total_reg <= total_next;
            frame_done_reg <= frame_done_next;
        end
    end

    // Exposure control
    logic [15:0] shutter;

    fspd_exposure u_exposure (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .frame_done_i(frame_done_reg),
        .peak_i(peak_reg),
        .total_i(total_reg),
        .shutter_o(shutter)
    );

    // Pixel dump
    logic [8:0] ptr_reg;
    logic [8:0] ptr_next;
    logic [7:0] dump_byte_reg;
    logic [7:0] dump_byte_next;
    logic ready_reg;
    logic ready_next;
    logic wrap_reg;
    logic wrap_next;
    logic armed_reg;
    logic armed_next;
    logic dump_wr;
    logic dump_rd;
    logic capture;

    always_comb begin
        dump_wr = req_i.wr && (req_i.addr == `FSPD_ADDR_DUMP);
        dump_rd = req_i.rd && (req_i.addr == `FSPD_ADDR_DUMP) && ready_reg;
        capture = armed_reg && pix_valid_i && (cur_idx == ptr_reg);
        ptr_next = ptr_reg;
        dump_byte_next = dump_byte_reg;
        ready_next = ready_reg;
        wrap_next = wrap_reg;
        armed_next = armed_reg;
        // Restart wins over a read or capture in the same cycle
        if (dump_wr) begin
            ptr_next = 9'h000;
            ready_next = 1'b0;
            wrap_next = 1'b1;
            armed_next = 1'b1;
        end else if (dump_rd) begin
            ready_next = 1'b0;
            armed_next = 1'b1;
            if (ptr_reg == PIX_LAST) begin
                ptr_next = 9'h000;
                wrap_next = 1'b1;
            end else begin
                ptr_next = ptr_reg + 9'h001;
                wrap_next = 1'b0;
            end
        end else if (capture) begin
            dump_byte_next = pix_beat_i.data;
            ready_next = 1'b1;
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_reg <= 9'h000;
            dump_byte_reg <= 8'h00;
            ready_reg <= 1'b0;
            wrap_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            ptr_reg <= ptr_next;
            dump_byte_reg <= dump_byte_next;
            ready_reg <= ready_next;
            wrap_reg <= wrap_next;
            armed_reg <= armed_next;
        end
    end

    assign dump_byte_ready_flag_o = ready_reg;
    assign dump_wrap_flag_o = wrap_reg;

    // Register reads; lower exposure byte comes from a shadow taken on the upper read
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic [7:0] shut_lo_reg;
    logic [7:0] shut_lo_next;

    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = req_i.rd;
        shut_lo_next = shut_lo_reg;
        if (req_i.rd) begin
            if (req_i.addr == `FSPD_ADDR_SHUT_UP) begin
                rd_data_next = shutter[15:8];
                shut_lo_next = shutter[7:0];
            end else if (req_i.addr == `FSPD_ADDR_SHUT_LO) begin
                rd_data_next = shut_lo_reg;
            end else if (req_i.addr == `FSPD_ADDR_PEAK) begin
                rd_data_next = peak_reg;
            end else if (req_i.addr == `FSPD_ADDR_TOTAL) begin
                rd_data_next = total_reg;
            end else if (req_i.addr == `FSPD_ADDR_FLOOR) begin
                rd_data_next = floor_reg;
            end else if (req_i.addr == `FSPD_ADDR_DUMP) begin
                rd_data_next = dump_byte_reg;
            end else begin
                rd_data_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            shut_lo_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            shut_lo_reg <= shut_lo_next;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;

    dump_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dump_wr |=> ptr_reg == 9'h000 && !ready_reg && armed_reg)
        else $error("dump write did not restart pointer");

    wrap_on_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dump_wr |=> wrap_reg)
        else $error("wrap flag not set by dump write");

    dump_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        capture && !dump_wr && !dump_rd |=> ready_reg && dump_byte_reg == $past(pix_beat_i.data))
        else $error("captured pixel not presented");

    dump_advance_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dump_rd && !dump_wr && ptr_reg != PIX_LAST |=> ptr_reg == $past(ptr_reg) + 9'h001
            && !wrap_reg && !ready_reg)
        else $error("pointer did not advance after read");

    dump_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dump_rd && !dump_wr && ptr_reg == PIX_LAST |=> ptr_reg == 9'h000 && wrap_reg)
        else $error("pointer did not wrap after last pixel");

    ptr_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ptr_reg <= PIX_LAST && idx_reg <= PIX_LAST + 9'h001)
        else $error("pixel address beyond array");

    stat_ceil_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        peak_reg <= `FSPD_STAT_CEIL && floor_reg <= `FSPD_STAT_CEIL)
        else $error("peak or floor above ceiling");

    total_value_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_end && sum_hi <= `FSPD_SUM_CEIL |=> total_reg == $past(sum_hi))
        else $error("sum byte not upper bits of total");

    total_ceil_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        total_reg <= `FSPD_SUM_CEIL)
        else $error("sum byte above ceiling");

    stat_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !frame_end |=> $stable(peak_reg) && $stable(floor_reg) && $stable(total_reg))
        else $error("statistics changed mid frame");

    floor_latch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_end && acc_min_next <= `FSPD_STAT_CEIL |=> floor_reg == $past(acc_min_next))
        else $error("floor not latched at frame end");

    peak_latch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        frame_end && acc_max_next <= `FSPD_STAT_CEIL |=> peak_reg == $past(acc_max_next))
        else $error("peak not latched at frame end");

    ready_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ready_reg && !dump_rd && !dump_wr |=> ready_reg && $stable(dump_byte_reg))
        else $error("dump byte lost before read");

    early_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i.rd && req_i.addr == `FSPD_ADDR_DUMP && !ready_reg && !dump_wr
            |=> $stable(ptr_reg))
        else $error("pointer moved on read without ready");

    shut_pair_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i.rd && req_i.addr == `FSPD_ADDR_SHUT_UP ##1 req_i.rd
            && req_i.addr == `FSPD_ADDR_SHUT_LO |=> rd_data_reg == $past(shutter[7:0], 2))
        else $error("exposure halves from different samples");

endmodule : fspd_top

// ---- dv/fspd_host_model.sv ----
// Host side of the register port: single reads, writes, paired exposure reads, dump polling.
// Assumes the block answers a read exactly one cycle after the strobe edge.
`timescale 1ns/1ps
`include "fspd_cfg.svh"

module fspd_host_model (
    // Clock
    input wire logic clk_i,
    // Block answers
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    input wire logic ready_i,
    // Requests
    output fspd_pkg::fspd_req_type req_o
);
    import fspd_pkg::*;

    initial req_o = '0;

    // Address goes to junk after release so stale values never look valid
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        d = rd_data_i;
        v = rd_valid_i;
    endtask : rd

    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        @(negedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
    endtask : wr

    // Upper byte first, lower directly after, nothing between
    // Strobe stays up across both edges so the pair is truly back to back
    task automatic rd_shutter(output logic [15:0] s, output logic v);
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: `FSPD_ADDR_SHUT_UP, wdata: 8'h00};
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: `FSPD_ADDR_SHUT_LO, wdata: 8'h00};
        s[15:8] = rd_data_i;
        v = rd_valid_i;
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~`FSPD_ADDR_SHUT_LO, wdata: 8'hA5};
        s[7:0] = rd_data_i;
        v = v & rd_valid_i;
    endtask : rd_shutter

    // Bounded poll of the ready flag before touching the dump port
    task automatic grab(output logic [7:0] d, output logic v);
        int n;
        n = 0;
        while (ready_i !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        rd(`FSPD_ADDR_DUMP, d, v);
    endtask : grab

    // Mean intensity estimate from the sum byte
    function automatic int avg_est(input logic [7:0] s);
        return (int'(s) * 128) / 121;
    endfunction : avg_est
endmodule : fspd_host_model

// ---- dv/frame_stats_pixel_dump_tb.sv ----
// Self-checking bench: random frames, exposure tracking, full dump sweep with wrap.
// Assumes a shortened array (LAST) so a whole dump sweep fits the run.
`timescale 1ns/1ps
`include "fspd_cfg.svh"

module frame_stats_pixel_dump_tb;
    import fspd_pkg::*;
    localparam logic [8:0] LAST = 9'h0C7;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    fspd_req_type req;
    fspd_beat_type beat = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic pix_valid = 1'b0;
    logic rdy;
    logic wrap;
    int fails = 0;
    int comparisons = 0;
    int ptr = 0;
    logic armed = 1'b0;
    logic [31:0] seed = 32'd80897;
    logic [15:0] shut = `FSPD_SHUT_RST;
    logic [7:0] pix [0:360];

    always #10 clk_i = ~clk_i;

    fspd_top #(.PIX_LAST(LAST)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .pix_valid_i(pix_valid),
        .pix_beat_i(beat), .dump_byte_ready_flag_o(rdy), .dump_wrap_flag_o(wrap));

    fspd_host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .ready_i(rdy), .req_o(req));

    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd8

    function automatic logic [7:0] clip(input int v, input int ceil);
        return 8'((v > ceil) ? ceil : v);
    endfunction : clip

    // Saturating one-step exposure move per frame
    function automatic logic [15:0] nshut(input logic [15:0] s, input logic [7:0] pk,
                                          input logic [7:0] sm);
        if (pk > `FSPD_PEAK_HI || sm > `FSPD_AVG_HI) begin
            return (s > `FSPD_SHUT_MIN + `FSPD_SHUT_STEP) ? s - `FSPD_SHUT_STEP : `FSPD_SHUT_MIN;
        end
        if (sm < `FSPD_AVG_LO) begin
            return (s < `FSPD_SHUT_MAX - `FSPD_SHUT_STEP) ? s + `FSPD_SHUT_STEP : `FSPD_SHUT_MAX;
        end
        return s;
    endfunction : nshut

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Mode 1 all bright, mode 2 all dark, else random; idle gaps scramble the data
    task automatic step(input int mode);
        logic [7:0] d;
        logic v;
        logic [15:0] s;
        int sum;
        int hi;
        int lo;
        int i;
        sum = 0;
        hi = 0;
        lo = 255;
        for (i = 0; i <= LAST; i++) begin
            pix[i] = (mode == 1) ? 8'hFF : (mode == 2) ? 8'h00 : rnd8();
            sum += pix[i];
            hi = (pix[i] > hi) ? pix[i] : hi;
            lo = (pix[i] < lo) ? pix[i] : lo;
        end
        i = 0;
        while (i <= LAST) begin
            @(negedge clk_i);
            if (rnd8() < 8'h40) begin
                pix_valid = 1'b0;
                beat = ~beat;
            end else begin
                pix_valid = 1'b1;
                beat = '{sof: (i == 0), data: pix[i]};
                i++;
            end
        end
        @(negedge clk_i);
        pix_valid = 1'b0;
        shut = nshut(shut, clip(hi, 254), clip(sum >> 9, 240));
        repeat (2) @(negedge clk_i);
        host.rd(`FSPD_ADDR_PEAK, d, v);
        chk("peak", clip(hi, 254), d);
        host.rd(`FSPD_ADDR_TOTAL, d, v);
        chk("total", clip(sum >> 9, 240), d);
        chk("mean", 16'(host.avg_est(clip(sum >> 9, 240))), 16'(host.avg_est(d)));
        host.rd(`FSPD_ADDR_FLOOR, d, v);
        chk("floor", clip(lo, 254), d);
        chk("read valid", 16'h0001, v);
        host.rd_shutter(s, v);
        chk("shutter", shut, s);
        if (armed) begin
            chk("ready", 16'h0001, rdy);
            chk("wrap", 16'(ptr == 0), wrap);
            host.grab(d, v);
            chk("dump byte", pix[ptr], d);
            ptr = (ptr == LAST) ? 0 : ptr + 1;
            chk("ready after read", 16'h0000, rdy);
            chk("wrap after read", 16'(ptr == 0), wrap);
        end else begin
            chk("idle ready", 16'h0000, rdy);
        end
    endtask : step

    initial begin
        logic [7:0] d;
        logic v;
        logic [15:0] s;
        int k;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        host.rd_shutter(s, v);
        chk("shutter after reset", shut, s);
        host.rd(`FSPD_ADDR_PEAK, d, v);
        chk("peak after reset", 16'h0000, d);
        host.rd(7'h3C, d, v);
        chk("unmapped", 16'h0000, d);
        step(1);
        step(2);
        host.wr(`FSPD_ADDR_DUMP, rnd8());
        armed = 1'b1;
        ptr = 0;
        chk("wrap on write", 16'h0001, wrap);
        chk("ready on write", 16'h0000, rdy);
        // Early read while not ready must not move the pointer
        host.rd(`FSPD_ADDR_DUMP, d, v);
        chk("early read wrap", 16'h0001, wrap);
        for (k = 0; k <= LAST + 3; k++) begin
            step((k % 50 == 7) ? 2 : 0);
        end
        host.wr(`FSPD_ADDR_DUMP, 8'h00);
        ptr = 0;
        chk("wrap on rewrite", 16'h0001, wrap);
        step(0);
        close_out();
    end

    // Sweep needs about 60k cycles; cut off at 100k
    initial begin
        #2000000;
        fails++;
        close_out();
    end
endmodule : frame_stats_pixel_dump_tb
